//--- rtl/udhc_pkg.sv
// Package for the device configuration register slice: command codes,
// field positions, reset values and suspend timing.
// Assumes a 25 MHz system clock; used by the register bank only, not by the clock divider.
package udhc_pkg;
   // Command codes on the shared parallel bus
   localparam logic [7:0] CMD_HWCFG_WR = 8'h_BA;
   localparam logic [7:0] CMD_HWCFG_RD = 8'h_BB;
   localparam logic [7:0] CMD_MODE_WR = 8'h_B8;
   localparam logic [7:0] CMD_MODE_RD = 8'h_B9;
   // Device mode register fields
   localparam int MODE_SOFT_ATTACH_BIT = 0;
   localparam int MODE_DEBUG_INT_BIT = 2;
   localparam int MODE_SUSPEND_REQ_BIT = 5;
   // Bits 1, 4, 6 and 7 are reserved and read as zero
   localparam logic [7:0] MODE_WRITE_MASK = 8'h_2D;
   localparam logic [7:0] MODE_RESET = 8'h_00;
   // Hardware configuration fields
   localparam int HW_EXT_PULLUP_BIT = 14;
   localparam int HW_SLOW_CLK_DIS_BIT = 13;
   localparam int HW_CLK_KEEP_BIT = 12;
   localparam int HW_DIV_LSB = 8;
   localparam logic [15:0] HW_WRITE_MASK = 16'h_7FFF;
   localparam logic [15:0] HW_RESET = 16'h_2340;
   // Suspend delay
   localparam int CLK_MHZ = 25;
   localparam int SUSP_DELAY_US = 2000;
   localparam int SUSP_DELAY_CYC = SUSP_DELAY_US * CLK_MHZ;
   // Slow suspend clock: about 100 kHz
   localparam int SLOW_CLK_KHZ = 100;
   localparam int SLOW_HALF_CYC = (CLK_MHZ * 1000) / (2 * SLOW_CLK_KHZ);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WR_WORD = 2'b01,
      ST_RD_WORD = 2'b10
   } udhc_cmd_state_type;
endpackage : udhc_pkg

//--- rtl/udhc_clk_div.sv
// Glitch-free divided clock output for the device.
// Assumes a one-cycle enable pulse at the fast base rate from the parent.
`timescale 1ns/10ps
module udhc_clk_div (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [3:0] divider,
   output logic clk_out
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] div_q;
   logic [3:0] div_d;
   logic out_q;
   logic wrap;
   logic [4:0] half;
   // Divider only reloaded at a period end, so no runt pulse appears
   assign half = ({1'b0, div_q} + 5'h_01) >> 1;
   assign wrap = (cnt_q == div_q);
   assign cnt_d = wrap ? 4'h_0 : 4'(cnt_q + 4'h_1);
   assign div_d = wrap ? divider : div_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_q <= 4'h_0;
         div_q <= 4'h_3;
         out_q <= 1'b0;
      end else if (tick) begin
         cnt_q <= cnt_d;
         div_q <= div_d;
         out_q <= ({1'b0, cnt_q} < half) || (div_q == 4'h_0 && !out_q);
      end
   end
   assign clk_out = out_q;
endmodule : udhc_clk_div

//--- rtl/udhc_config_regs.sv
// Device mode and hardware configuration registers reached by command codes.
// Assumes a host that writes a command, then one data word, on the same clock.
`timescale 1ns/10ps
module udhc_config_regs (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic data_wr_valid,
   input wire logic [15:0] data_wr,
   input wire logic data_rd_strobe,
   output logic [15:0] data_rd,
   output logic data_rd_valid,
   input wire logic usb_bus_reset,
   input wire logic clk48_tick,
   input wire logic ep_ack_bulk,
   input wire logic ep_iso_done,
   input wire logic ep_nak,
   input wire logic ep_error,
   output logic ep_int_event,
   output logic soft_pullup_on,
   output logic clock_output_pin,
   output logic osc_enable,
   output logic suspended,
   output logic [7:0] hw_cfg_low
);
   logic [15:0] hw_q;
   logic [15:0] hw_d;
   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic [15:0] rd_q;
   logic rd_valid_q;
   logic int_q;
   logic is_hw;
   logic is_hw_q;
   logic [15:0] rd_word;
   udhc_pkg::udhc_cmd_state_type state_q;
   udhc_pkg::udhc_cmd_state_type state_d;
   logic susp_q;
   logic req_prev_q;
   logic [16:0] susp_cnt_q;
   logic susp_late;
   logic [7:0] slow_cnt_q;
   logic slow_q;
   logic div_clk;
   logic ext_pull;
   logic slow_dis;
   logic keep_run;
   logic dbg;
   logic wr_hw;
   logic wr_mode;
   logic cmd_take;
   logic wr_take;
   logic rd_take;
   logic susp_start;
   logic pin_d;
   logic pin_q;

   // Write and read codes are checked in the decoder and in the target latch
   function automatic logic udhc_is_wr(input logic [7:0] code);
      return (code == udhc_pkg::CMD_HWCFG_WR) || (code == udhc_pkg::CMD_MODE_WR);
   endfunction : udhc_is_wr

   function automatic logic udhc_is_rd(input logic [7:0] code);
      return (code == udhc_pkg::CMD_HWCFG_RD) || (code == udhc_pkg::CMD_MODE_RD);
   endfunction : udhc_is_rd

   assign is_hw = (cmd_code == udhc_pkg::CMD_HWCFG_WR) || (cmd_code == udhc_pkg::CMD_HWCFG_RD);
   // Unknown codes leave the target select alone
   assign cmd_take = cmd_valid && (state_q == udhc_pkg::ST_IDLE)
      && (udhc_is_wr(cmd_code) || udhc_is_rd(cmd_code));
   assign wr_take = (state_q == udhc_pkg::ST_WR_WORD) && data_wr_valid;
   assign rd_take = (state_q == udhc_pkg::ST_RD_WORD) && data_rd_strobe;
   assign ext_pull = hw_q[udhc_pkg::HW_EXT_PULLUP_BIT];
   assign slow_dis = hw_q[udhc_pkg::HW_SLOW_CLK_DIS_BIT];
   assign keep_run = hw_q[udhc_pkg::HW_CLK_KEEP_BIT];
   assign dbg = mode_q[udhc_pkg::MODE_DEBUG_INT_BIT];

   // Command decode: one word per command, then back to idle
   always_comb begin
      state_d = state_q;
      case (state_q)
         udhc_pkg::ST_IDLE: begin
            if (cmd_valid && udhc_is_wr(cmd_code)) begin
               state_d = udhc_pkg::ST_WR_WORD;
            end else if (cmd_valid && udhc_is_rd(cmd_code)) begin
               state_d = udhc_pkg::ST_RD_WORD;
            end
         end
         udhc_pkg::ST_WR_WORD: begin
            if (data_wr_valid) begin
               state_d = udhc_pkg::ST_IDLE;
            end
         end
         udhc_pkg::ST_RD_WORD: begin
            if (data_rd_strobe) begin
               state_d = udhc_pkg::ST_IDLE;
            end
         end
         default: state_d = udhc_pkg::ST_IDLE;
      endcase
   end

   assign wr_hw = wr_take && is_hw_q;
   assign wr_mode = wr_take && !is_hw_q;
   assign hw_d = wr_hw ? (data_wr & udhc_pkg::HW_WRITE_MASK) : hw_q;
   assign mode_d = wr_mode ? (data_wr[7:0] & udhc_pkg::MODE_WRITE_MASK) : mode_q;
   assign rd_word = is_hw_q ? hw_q : {8'h_00, mode_q};

   // usb_bus_reset deliberately unused here: programmed bits survive it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= udhc_pkg::ST_IDLE;
         is_hw_q <= 1'b0;
         hw_q <= udhc_pkg::HW_RESET;
         mode_q <= udhc_pkg::MODE_RESET;
      end else begin
         state_q <= state_d;
         if (cmd_take) begin
            is_hw_q <= is_hw;
         end
         hw_q <= hw_d;
         mode_q <= mode_d;
      end
   end

   // Read word captured on the strobe so data comes from a flop
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_q <= 16'h_0000;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_take;
         if (rd_take) begin
            rd_q <= rd_word;
         end
      end
   end
   assign data_rd = rd_q;
   assign data_rd_valid = rd_valid_q;
   assign hw_cfg_low = hw_q[7:0];

   // Endpoint interrupt selection by debug mode
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         int_q <= 1'b0;
      end else if (dbg) begin
         int_q <= ep_nak || ep_error;
      end else begin
         int_q <= ep_ack_bulk || ep_iso_done;
      end
   end
   assign ep_int_event = int_q;

   // External resistor fitted overrides the soft attach bit
   assign soft_pullup_on = mode_q[udhc_pkg::MODE_SOFT_ATTACH_BIT] && !ext_pull;

   // Suspend: a written one then zero on the request bit starts it
   assign susp_late = (susp_cnt_q == 17'(udhc_pkg::SUSP_DELAY_CYC));
   assign susp_start = req_prev_q && !mode_q[udhc_pkg::MODE_SUSPEND_REQ_BIT];
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         req_prev_q <= 1'b0;
         susp_q <= 1'b0;
         susp_cnt_q <= 17'h_0_0000;
      end else begin
         req_prev_q <= mode_q[udhc_pkg::MODE_SUSPEND_REQ_BIT];
         if (susp_start) begin
            susp_q <= 1'b1;
            susp_cnt_q <= 17'h_0_0000;
         end else if (usb_bus_reset || cmd_valid) begin
            // Bus activity or host access ends suspend
            susp_q <= 1'b0;
         end else if (susp_q && !susp_late) begin
            susp_cnt_q <= 17'(susp_cnt_q + 17'h_0_0001);
         end
      end
   end
   assign suspended = susp_q && susp_late;

   // Slow suspend clock, about 100 kHz
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         slow_cnt_q <= 8'h_00;
         slow_q <= 1'b0;
      end else if (slow_cnt_q == 8'(udhc_pkg::SLOW_HALF_CYC - 1)) begin
         slow_cnt_q <= 8'h_00;
         slow_q <= !slow_q;
      end else begin
         slow_cnt_q <= 8'(slow_cnt_q + 8'h_01);
      end
   end

   udhc_clk_div u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(clk48_tick),
      .divider(hw_q[udhc_pkg::HW_DIV_LSB +: 4]),
      .clk_out(div_clk)
   );

   // Output mux changes only on the suspend edge; a tradeoff over a full glitch-free mux
   assign pin_d = !suspended ? div_clk : (slow_dis ? 1'b0 : slow_q);
   // Pin from a flop, so select decode hazards never reach it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
      end
   end
   assign clock_output_pin = pin_q;
   assign osc_enable = keep_run || !suspended;
endmodule : udhc_config_regs

//--- sim/udhc_props.sv
// Port checker for the configuration register slice.
// Assumes a bind onto udhc_config_regs, one clock, sync active-low reset.
`timescale 1ns/10ps
module udhc_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic data_rd_strobe,
   input wire logic data_rd_valid,
   input wire logic data_wr_valid,
   input wire logic usb_bus_reset,
   input wire logic ep_ack_bulk,
   input wire logic ep_iso_done,
   input wire logic ep_nak,
   input wire logic ep_error,
   input wire logic ep_int_event,
   input wire logic soft_pullup_on,
   input wire logic osc_enable,
   input wire logic suspended,
   input wire logic [7:0] hw_cfg_low
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_rd_has_cause: assert property (data_rd_valid |-> $past(data_rd_strobe))
      else $error("read word without request");
   a_rd_one_pulse: assert property (data_rd_valid |=> !data_rd_valid)
      else $error("read valid longer than one cycle");
   a_int_has_cause: assert property (ep_int_event |->
      $past(ep_ack_bulk | ep_iso_done | ep_nak | ep_error))
      else $error("interrupt without endpoint event");
   a_osc_awake_on: assert property (!suspended |-> osc_enable)
      else $error("oscillator off while awake");
   a_low_kept_reset: assert property (usb_bus_reset && !data_wr_valid
      |=> $stable(hw_cfg_low))
      else $error("bus reset changed lower byte");
   a_pull_kept_reset: assert property (usb_bus_reset && !data_wr_valid
      |=> $stable(soft_pullup_on))
      else $error("bus reset changed pull-up");
   a_pull_needs_write: assert property ($changed(soft_pullup_on) |-> $past(data_wr_valid))
      else $error("pull-up moved without write");
   a_low_needs_write: assert property ($changed(hw_cfg_low) |-> $past(data_wr_valid))
      else $error("lower byte moved without write");
endmodule : udhc_props

//--- sim/udhc_host_model.sv
// Host microprocessor model issuing command codes and one data word.
// Assumes the bench calls put and get; drives 1 ns after rising edges.
`timescale 1ns/10ps
module udhc_host_model (
   input wire logic clk_sys,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic data_wr_valid,
   output logic [15:0] data_wr,
   output logic data_rd_strobe,
   input wire logic [15:0] data_rd,
   input wire logic data_rd_valid
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h_00;
      data_wr_valid = 1'b0;
      data_wr = 16'h_0000;
      data_rd_strobe = 1'b0;
   end
   task automatic put(input logic [7:0] code, input logic [15:0] word);
      @(posedge clk_sys);
      #1 cmd_valid = 1'b1;
      cmd_code = code;
      @(posedge clk_sys);
      #1 cmd_valid = 1'b0;
      cmd_code = ~code;
      data_wr_valid = 1'b1;
      data_wr = word;
      @(posedge clk_sys);
      #1 data_wr_valid = 1'b0;
      data_wr = ~word; // Released bus must not look valid
   endtask : put
   task automatic get(input logic [7:0] code, output logic [15:0] word);
      int n;
      @(posedge clk_sys);
      #1 cmd_valid = 1'b1;
      cmd_code = code;
      @(posedge clk_sys);
      #1 cmd_valid = 1'b0;
      cmd_code = ~code;
      data_rd_strobe = 1'b1;
      @(posedge clk_sys);
      #1 data_rd_strobe = 1'b0;
      n = 0;
      while (data_rd_valid !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1 n++;
      end
      // A missing answer must not pass for the old word
      word = (data_rd_valid === 1'b1) ? data_rd : 16'h_xxxx;
   endtask : get
endmodule : udhc_host_model

//--- sim/usb_device_hw_config_regs_test.sv
// Self-checking bench for the configuration register slice.
// Assumes udhc_config_regs, the host model and the port checker.
`timescale 1ns/10ps
module usb_device_hw_config_regs_test;
   logic clk_sys = 1'b0, rst_n = 1'b0, usb_bus_reset = 1'b0, clk48_tick = 1'b0;
   logic cmd_valid, data_wr_valid, data_rd_strobe, data_rd_valid, ep_int_event;
   logic soft_pullup_on, clock_output_pin, osc_enable, suspended;
   logic [7:0] cmd_code, hw_cfg_low;
   logic [15:0] data_wr, data_rd, w;
   logic [3:0] ev = 4'h_0;
   logic ep_ack_bulk, ep_iso_done, ep_nak, ep_error;
   int bad_count = 0, total_checks = 0;
   assign {ep_error, ep_nak, ep_iso_done, ep_ack_bulk} = ev;
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) #1 clk48_tick = ~clk48_tick;
   udhc_config_regs u_udhc_config_regs (.clk_sys, .rst_n, .cmd_valid, .cmd_code,
      .data_wr_valid, .data_wr, .data_rd_strobe, .data_rd, .data_rd_valid,
      .usb_bus_reset, .clk48_tick, .ep_ack_bulk, .ep_iso_done, .ep_nak, .ep_error,
      .ep_int_event, .soft_pullup_on, .clock_output_pin, .osc_enable, .suspended,
      .hw_cfg_low);
   udhc_host_model u_udhc_host_model (.clk_sys, .cmd_valid, .cmd_code, .data_wr_valid,
      .data_wr, .data_rd_strobe, .data_rd, .data_rd_valid);
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task automatic count_rises(input int cycles, output int n);
      logic p;
      n = 0;
      #1 p = clock_output_pin;
      repeat (cycles) begin
         @(posedge clk_sys);
         #1 n += int'(clock_output_pin && !p);
         p = clock_output_pin;
      end
   endtask : count_rises
   task automatic t_reset;
      u_udhc_host_model.get(8'h_BB, w);
      chk("hw reset", 16'h_2340, w);
      u_udhc_host_model.get(8'h_B9, w);
      chk("mode reset", 16'h_0000, w);
      chk("osc awake", 16'h_0001, {15'h_0000, osc_enable});
      $display("t_reset done");
   endtask : t_reset
   task automatic t_hwcfg;
      u_udhc_host_model.put(8'h_BA, 16'h_FFFF);
      u_udhc_host_model.get(8'h_BB, w);
      chk("hw all ones", 16'h_7FFF, w);
      chk("low byte", 16'h_00FF, {8'h_00, hw_cfg_low});
      u_udhc_host_model.put(8'h_BA, 16'h_0A55);
      u_udhc_host_model.get(8'h_BB, w);
      chk("hw pattern", 16'h_0A55, w);
      $display("t_hwcfg done");
   endtask : t_hwcfg
   task automatic t_attach;
      u_udhc_host_model.put(8'h_B8, 16'h_00FF);
      chk("pull-up on", 16'h_0001, {15'h_0000, soft_pullup_on});
      u_udhc_host_model.get(8'h_B9, w);
      chk("mode mask", 16'h_002D, w);
      u_udhc_host_model.put(8'h_BA, 16'h_4000);
      chk("pull-up ext", 16'h_0000, {15'h_0000, soft_pullup_on});
      @(posedge clk_sys);
      #1 usb_bus_reset = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 usb_bus_reset = 1'b0;
      u_udhc_host_model.get(8'h_BB, w);
      chk("hw kept", 16'h_4000, w);
      u_udhc_host_model.get(8'h_B9, w);
      chk("mode kept", 16'h_002D, w);
      $display("t_attach done");
   endtask : t_attach
   task automatic t_clock;
      int n;
      u_udhc_host_model.put(8'h_BA, 16'h_0500);
      repeat (40) @(posedge clk_sys);
      count_rises(240, n);
      // Tick every second cycle: divider 5 gives a 12-cycle period
      chk("clock rises", 16'h_0014, 16'(n));
      $display("t_clock done");
   endtask : t_clock
   task automatic t_suspend;
      int n;
      u_udhc_host_model.put(8'h_BA, 16'h_0000);
      u_udhc_host_model.put(8'h_B8, 16'h_0020);
      u_udhc_host_model.put(8'h_B8, 16'h_0000);
      // Host stays quiet here: any command ends suspend
      repeat (49000) @(posedge clk_sys);
      #1 chk("early suspend", 16'h_0000, {15'h_0000, suspended});
      chk("osc early", 16'h_0001, {15'h_0000, osc_enable});
      repeat (2000) @(posedge clk_sys);
      #1 chk("suspend", 16'h_0001, {15'h_0000, suspended});
      chk("osc stopped", 16'h_0000, {15'h_0000, osc_enable});
      count_rises(1000, n);
      // Slow clock near 100 kHz: 2 to 6 rises in 1000 cycles
      chk("slow clock", 16'h_0001, {15'h_0000, ((n >= 2) && (n <= 6))});
      u_udhc_host_model.get(8'h_BB, w);
      chk("hw in suspend", 16'h_0000, w);
      chk("woken", 16'h_0000, {15'h_0000, suspended});
      chk("osc woken", 16'h_0001, {15'h_0000, osc_enable});
      $display("t_suspend done");
   endtask : t_suspend
   task automatic t_events;
      for (int m = 0; m < 2; m++) begin
         u_udhc_host_model.put(8'h_B8, m ? 16'h_0004 : 16'h_0000);
         for (int e = 0; e < 4; e++) begin
            @(posedge clk_sys);
            #1 ev = 4'h_1 << e;
            @(posedge clk_sys);
            #1 ev = 4'h_0;
            chk("int event", {15'h_0000, (m == 1) == (e >= 2)},
               {15'h_0000, ep_int_event});
         end
      end
      $display("t_events done");
   endtask : t_events
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      t_reset();
      t_hwcfg();
      t_attach();
      t_events();
      t_clock();
      t_suspend();
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      end_of_test();
   end
endmodule : usb_device_hw_config_regs_test
bind udhc_config_regs udhc_props u_udhc_props (.clk_sys, .rst_n, .data_rd_strobe,
   .data_rd_valid, .data_wr_valid, .usb_bus_reset, .ep_ack_bulk, .ep_iso_done, .ep_nak,
   .ep_error, .ep_int_event, .soft_pullup_on, .osc_enable, .suspended, .hw_cfg_low);
